// *** shared/ioc_regs.svh ***
`ifndef IOC_REGS_SVH
`define IOC_REGS_SVH

// Register numbers inside the device's address block
`define IOC_REG_IN_DATA   3'h0
`define IOC_REG_IN_STAT   3'h2
`define IOC_REG_IN_CTRL   3'h3
`define IOC_REG_OUT_DATA  3'h5
`define IOC_REG_OUT_STAT  3'h6
`define IOC_REG_OUT_CTRL  3'h7

// Size of the address block claimed by the device
`define IOC_REG_SPAN      16'h0008

// Default device number of the first unit
`define IOC_DEV_NO_DFLT   16'h00C0

// Command word field positions
`define IOC_CMD_RDY_IE    0
`define IOC_CMD_ERR_IE    1
`define IOC_CMD_ACTIVATE  2
`define IOC_CMD_TEST      3
`define IOC_CMD_DEVCLR    4
`define IOC_CMD_UNIT_LO   9
`define IOC_CMD_MODE_HI   15

// Status word field positions
`define IOC_STS_RFT       3
`define IOC_STS_ERR_SUM   4
`define IOC_STS_ERR_LO    5
`define IOC_STS_ERR_HI    8

// Error indicator positions inside the four-bit error field
`define IOC_ERR_OVERRUN   0
`define IOC_ERR_LINE      1

// Reset values
`define IOC_CMD_RESET     16'h0000
`define IOC_ERR_RESET     4'h0
`define IOC_WORD_ZERO     16'h0000

`endif

// *** shared/ioc_pkg.sv ***
package ioc_pkg;

  // Request from the processor's I/O transfer instruction
  typedef struct packed {
    logic        rd;     // Read one device register
    logic        wr;     // Write one device register
    logic [15:0] addr;   // Device number plus register number
    logic [15:0] wdata;  // Accumulator contents on a write
  } ioc_io_req_t;

  // Interrupt requests of both channels
  typedef struct packed {
    logic in_rdy;
    logic in_err;
    logic out_rdy;
    logic out_err;
  } ioc_irq_t;

  // Output channel sequence, Gray along empty, full, sending
  typedef enum logic [1:0] {
    IOC_TX_EMPTY = 2'b00,
    IOC_TX_FULL  = 2'b01,
    IOC_TX_SEND  = 2'b11
  } ioc_tx_state_t;

  // State of the channel pair, apart from the two holding registers
  typedef struct packed {
    logic [15:0]   cmd_in;    // Input channel command word
    logic [15:0]   cmd_out;   // Output channel command word
    logic [3:0]    err_in;    // Input error indicators
    logic [3:0]    err_out;   // Output error indicators
    ioc_tx_state_t tx_st;     // Output channel sequence
    logic          tx_valid;  // Character offered to the device
    logic [15:0]   rdata;     // Read answer
    logic          ack;       // Access answered
    ioc_irq_t      irq;       // Registered interrupt requests
  } ioc_state_t;

endpackage

// *** core/ioc_data_hold.sv ***
`timescale 1ns/10ps

module ioc_data_hold #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Control
  input  wire logic         clr_i,
  input  wire logic         load_i,
  input  wire logic         take_i,
  // Data
  input  wire logic [W-1:0] data_i,
  output logic      [W-1:0] data_o,
  output logic              valid_o
);

  // One held word and its valid flag; clear first, then load beats take
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_o  <= '0;
      valid_o <= 1'b0;
    end else if (clr_i) begin
      data_o  <= '0;
      valid_o <= 1'b0;
    end else if (load_i) begin
      data_o  <= data_i;
      valid_o <= 1'b1;
    end else if (take_i) begin
      valid_o <= 1'b0;
    end
  end

endmodule

// *** core/ioc_channel.sv ***
`timescale 1ns/10ps
`include "ioc_regs.svh"

// Overview of operation
// - Register address is device number plus register number
// - Device claims a block of eight registers
// - DMA build offers no data registers
// - Data registers carry the device's character format
// - Status built internally, read as whole word
// - Both channels share one status layout
// - Status bits 0-2 echo command bits 0-2
// - Input ready means unread data held
// - Output ready means data register empty
// - DMA build keeps the same ready meanings
// - Status bit 4 ORs the error indicators
// - Bits 5-8 errors, 9-10 unit, 11-15 mode
// - Every command write acts immediately
// - Both channels share one command layout
// - Command bits 0,1 enable ready, error interrupts
// - Activate enables receive, starts send, stays set
// - Test mode loops output back as input
// - Device clear resets both channels entirely
// - Ready interrupt when ready and enabled

module ioc_channel #(
  parameter logic [15:0] DEV_NO    = `IOC_DEV_NO_DFLT,  // Device number of this unit
  parameter int          CHAR_W    = 8,                 // Character width on the device side
  parameter bit          DMA_STYLE = 1'b0               // Hide the data registers
) (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  // System master clear
  input  wire logic                 mclr_i,
  // Processor I/O transfer port
  input  wire ioc_pkg::ioc_io_req_t io_req_i,
  output logic               [15:0] io_rdata_o,
  output logic                      io_ack_o,
  // Receive side of the external device
  input  wire logic                 rx_valid_i,
  input  wire logic    [CHAR_W-1:0] rx_data_i,
  input  wire logic                 rx_err_i,
  // Transmit side of the external device
  output logic                      tx_valid_o,
  output logic         [CHAR_W-1:0] tx_data_o,
  input  wire logic                 tx_ready_i,
  input  wire logic                 tx_err_i,
  // Interrupt requests
  output ioc_pkg::ioc_irq_t         irq_o
);

  // Builds a status word from the command word, ready flag and errors
  // Test and clear bits of the command are not echoed; ready and error summary take their places
  function automatic logic [15:0] make_status(input logic [15:0] cmd,
                                              input logic        ready_for_transfer,
                                              input logic [3:0]  err);
    logic [15:0] s;
    s = `IOC_WORD_ZERO;
    s[`IOC_CMD_DEVCLR-1:0] = cmd[`IOC_CMD_DEVCLR-1:0];
    s[`IOC_CMD_TEST] = 1'b0;
    s[`IOC_CMD_ACTIVATE:0] = cmd[`IOC_CMD_ACTIVATE:0];
    s[`IOC_STS_RFT] = ready_for_transfer;
    s[`IOC_STS_ERR_SUM] = |err;
    s[`IOC_STS_ERR_HI:`IOC_STS_ERR_LO] = err;
    s[`IOC_CMD_MODE_HI:`IOC_CMD_UNIT_LO] = cmd[`IOC_CMD_MODE_HI:`IOC_CMD_UNIT_LO];
    return s;
  endfunction

  // Stored form of a command word; the clear bit is a pulse, never kept
  // A held clear bit would pin both channels in reset
  function automatic logic [15:0] keep_cmd(input logic [15:0] w);
    logic [15:0] c;
    c = w;
    c[`IOC_CMD_DEVCLR] = 1'b0;
    return c;
  endfunction

  // Registered state and its next value
  ioc_pkg::ioc_state_t st;
  ioc_pkg::ioc_state_t next_st;

  // Address decode
  logic [15:0]       reg_off;    // Address relative to the device number
  logic              reg_hit;    // Address falls in this device's block
  logic [2:0]        reg_no;     // Register number within the block
  logic              acc_rd;     // Mapped read
  logic              acc_wr;     // Mapped write

  // Channel control terms
  logic              dev_clr;    // Device clear or master clear
  logic              in_act;     // Input reception enabled
  logic              out_act;    // Output transmission enabled
  logic              test_mode;  // Loopback selected
  logic              rx_take;    // External character accepted
  logic              loop_xfer;  // Output character looped into input
  logic              in_load;    // Input holding register loads
  logic              in_read;    // Processor reads input data
  logic              out_write;  // Processor writes output data
  logic              out_load;   // Output holding register loads
  logic              out_take;   // Output holding register empties

  // Holding registers
  logic [CHAR_W-1:0] in_data;    // Character waiting for the processor
  logic              in_valid;   // Unread character held
  logic [CHAR_W-1:0] in_src;     // Source of the next input character
  logic [CHAR_W-1:0] out_data;   // Character waiting to go out
  logic              out_full;   // Output holding register occupied
  logic              out_rft;    // Output data register may be written
  logic [15:0]       sts_in;     // Input status word
  logic [15:0]       sts_out;    // Output status word

  // Input holding register
  // Cleared by device clear as well, so a stale character cannot survive
  ioc_data_hold #(
    .W       (CHAR_W)
  ) u_in_hold (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .clr_i   (dev_clr),
    .load_i  (in_load),
    .take_i  (in_read),
    .data_i  (in_src),
    .data_o  (in_data),
    .valid_o (in_valid)
  );

  // Output holding register
  // Loaded from the low bits of the write word; the high bits are ignored
  ioc_data_hold #(
    .W       (CHAR_W)
  ) u_out_hold (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .clr_i   (dev_clr),
    .load_i  (out_load),
    .take_i  (out_take),
    .data_i  (io_req_i.wdata[CHAR_W-1:0]),
    .data_o  (out_data),
    .valid_o (out_full)
  );

  // Next state of the channel pair
  always_comb begin
    next_st = st;
    next_st.ack = 1'b0;

    // Decode the block claimed by this device
    // Addresses below the device number wrap to a large offset and miss
    reg_off = io_req_i.addr - DEV_NO;
    reg_hit = reg_off < `IOC_REG_SPAN;
    reg_no  = reg_off[2:0];
    acc_rd  = io_req_i.rd & reg_hit;
    acc_wr  = io_req_i.wr & ~io_req_i.rd & reg_hit;

    // Device clear from either command word, or master clear
    // Either command register may carry it; both channels reset together
    dev_clr = (acc_wr & io_req_i.wdata[`IOC_CMD_DEVCLR] &
               ((reg_no == `IOC_REG_IN_CTRL) | (reg_no == `IOC_REG_OUT_CTRL))) | mclr_i;

    // Standard command bits of each channel
    // Test mode from either channel loops the pair
    in_act    = st.cmd_in[`IOC_CMD_ACTIVATE];
    out_act   = st.cmd_out[`IOC_CMD_ACTIVATE];
    test_mode = st.cmd_in[`IOC_CMD_TEST] | st.cmd_out[`IOC_CMD_TEST];

    // Input side: external character, or looped output while testing
    // The receive line is ignored while testing, so only the looped
    // character can reach the input holding register
    rx_take   = in_act & ~test_mode & rx_valid_i;
    loop_xfer = in_act & out_act & test_mode & (st.tx_st == ioc_pkg::IOC_TX_FULL);
    in_load   = rx_take | loop_xfer;
    in_src    = loop_xfer ? out_data : rx_data_i;
    in_read   = acc_rd & ~DMA_STYLE & (reg_no == `IOC_REG_IN_DATA);

    // Output side: a write is taken only while the register is empty
    // A write while busy is dropped: the character already on its way
    // stays put and the overrun indicator records the mistake
    out_rft   = (st.tx_st == ioc_pkg::IOC_TX_EMPTY);
    out_write = acc_wr & ~DMA_STYLE & (reg_no == `IOC_REG_OUT_DATA);
    out_load  = out_write & out_rft & ~dev_clr;
    out_take  = loop_xfer | ((st.tx_st == ioc_pkg::IOC_TX_SEND) & tx_ready_i);

    // Status words share one layout on both channels
    sts_in  = make_status(st.cmd_in, in_valid, st.err_in);
    sts_out = make_status(st.cmd_out, out_rft, st.err_out);

    // Output sequence
    // FULL waits there until the channel is activated; dropping activate
    // mid-send does not abort, the offer stands until it is taken
    unique case (st.tx_st)
      ioc_pkg::IOC_TX_EMPTY: begin
        if (out_load) begin
          next_st.tx_st = ioc_pkg::IOC_TX_FULL;
        end
      end
      ioc_pkg::IOC_TX_FULL: begin
        if (loop_xfer) begin
          next_st.tx_st = ioc_pkg::IOC_TX_EMPTY;
        end else if (out_act & ~test_mode) begin
          next_st.tx_st    = ioc_pkg::IOC_TX_SEND;
          next_st.tx_valid = 1'b1;
        end
      end
      ioc_pkg::IOC_TX_SEND: begin
        if (tx_ready_i) begin
          next_st.tx_st    = ioc_pkg::IOC_TX_EMPTY;
          next_st.tx_valid = 1'b0;
        end
      end
      default: begin
        next_st.tx_st    = ioc_pkg::IOC_TX_EMPTY;
        next_st.tx_valid = 1'b0;
      end
    endcase

    // Error indicators are sticky until a clear
    // An input overrun keeps the newer character; the older one is lost
    if (in_load & in_valid & ~in_read) begin
      next_st.err_in[`IOC_ERR_OVERRUN] = 1'b1;
    end
    if (rx_take & rx_err_i) begin
      next_st.err_in[`IOC_ERR_LINE] = 1'b1;
    end
    if (out_write & ~out_rft) begin
      next_st.err_out[`IOC_ERR_OVERRUN] = 1'b1;
    end
    if ((st.tx_st == ioc_pkg::IOC_TX_SEND) & tx_err_i) begin
      next_st.err_out[`IOC_ERR_LINE] = 1'b1;
    end

    // Command writes take effect at once
    // The write that carries a clear is overridden by the clear below
    if (acc_wr & (reg_no == `IOC_REG_IN_CTRL)) begin
      next_st.cmd_in = keep_cmd(io_req_i.wdata);
    end
    if (acc_wr & (reg_no == `IOC_REG_OUT_CTRL)) begin
      next_st.cmd_out = keep_cmd(io_req_i.wdata);
    end

    // Read answer, whole 16-bit word
    // Unused register numbers still answer, with zero
    if (acc_rd) begin
      next_st.ack = 1'b1;
      unique case (reg_no)
        `IOC_REG_IN_STAT:  next_st.rdata = sts_in;
        `IOC_REG_OUT_STAT: next_st.rdata = sts_out;
        `IOC_REG_IN_DATA:  next_st.rdata = DMA_STYLE ? `IOC_WORD_ZERO : 16'(in_data);
        default:           next_st.rdata = `IOC_WORD_ZERO;
      endcase
    end
    if (acc_wr) begin
      next_st.ack = 1'b1;
    end

    // Interrupt requests follow the status one cycle later
    // They are levels; software drops them through the cause or the enable
    next_st.irq.in_rdy  = sts_in[`IOC_STS_RFT] & st.cmd_in[`IOC_CMD_RDY_IE];
    next_st.irq.out_rdy = sts_out[`IOC_STS_RFT] & st.cmd_out[`IOC_CMD_RDY_IE];
    next_st.irq.in_err  = sts_in[`IOC_STS_ERR_SUM] & st.cmd_in[`IOC_CMD_ERR_IE];
    next_st.irq.out_err = sts_out[`IOC_STS_ERR_SUM] & st.cmd_out[`IOC_CMD_ERR_IE];

    // Clear wipes command and status of both channels
    // Placed last so that it overrides every update made above except the read answer and ack
    if (dev_clr) begin
      next_st.cmd_in   = `IOC_CMD_RESET;
      next_st.cmd_out  = `IOC_CMD_RESET;
      next_st.err_in   = `IOC_ERR_RESET;
      next_st.err_out  = `IOC_ERR_RESET;
      next_st.tx_st    = ioc_pkg::IOC_TX_EMPTY;
      next_st.tx_valid = 1'b0;
      next_st.irq      = '0;
    end
  end

  // State register
  // Every field is named in the reset branch so that none starts unknown
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st.cmd_in   <= `IOC_CMD_RESET;
      st.cmd_out  <= `IOC_CMD_RESET;
      st.err_in   <= `IOC_ERR_RESET;
      st.err_out  <= `IOC_ERR_RESET;
      st.tx_st    <= ioc_pkg::IOC_TX_EMPTY;
      st.tx_valid <= 1'b0;
      st.rdata    <= `IOC_WORD_ZERO;
      st.ack      <= 1'b0;
      st.irq      <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops
  // The offered character comes from the output holding register
  assign io_rdata_o = st.rdata;
  assign io_ack_o   = st.ack;
  assign tx_valid_o = st.tx_valid;
  assign tx_data_o  = out_data;
  assign irq_o      = st.irq;

endmodule

// *** tb/ioc_assertions.sv ***
`timescale 1ns/10ps

module ioc_assertions #(
  parameter logic [15:0] DEV_NO = 16'h00C0,  // Device number
  parameter int          CHAR_W = 8          // Character width
) (
  // Clock, reset, clear
  input wire logic                 clk_i,
  input wire logic                 rst_n_i,
  input wire logic                 mclr_i,
  // Processor port
  input wire ioc_pkg::ioc_io_req_t io_req_i,
  input wire logic          [15:0] io_rdata_o,
  input wire logic                 io_ack_o,
  // Device side
  input wire logic                 rx_valid_i,
  input wire logic    [CHAR_W-1:0] rx_data_i,
  input wire logic                 rx_err_i,
  input wire logic                 tx_valid_o,
  input wire logic    [CHAR_W-1:0] tx_data_o,
  input wire logic                 tx_ready_i,
  input wire logic                 tx_err_i,
  input wire ioc_pkg::ioc_irq_t    irq_o
);
  logic [15:0] off;     // Register number of the request
  logic        map;     // Access inside the block
  logic        rd_os;   // Output status read
  logic        rd_is;   // Input status read
  logic        clr_wr;  // Device clear write

  // Decode of the request
  assign off    = io_req_i.addr - DEV_NO;
  assign map    = (io_req_i.rd | io_req_i.wr) && off < 16'h0008;
  assign rd_os  = io_req_i.rd && off == 16'h0006;
  assign rd_is  = io_req_i.rd && off == 16'h0002;
  assign clr_wr = io_req_i.wr && !io_req_i.rd && io_req_i.wdata[4] && (off == 16'h0003 || off == 16'h0007);

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Status reads and the answer cycle
  sequence s_rd_os; rd_os && !mclr_i ##1 io_ack_o; endsequence
  sequence s_rd_is; rd_is && !mclr_i ##1 io_ack_o; endsequence

  property p_ack; map |=> io_ack_o; endproperty
  property p_noack; !map |=> !io_ack_o; endproperty
  property p_tx_hold; tx_valid_o && !tx_ready_i && !mclr_i && !clr_wr |=> tx_valid_o && $stable(tx_data_o); endproperty
  property p_tx_done; tx_valid_o && tx_ready_i |=> !tx_valid_o; endproperty
  property p_mclr; mclr_i |=> irq_o == 4'h0 && !tx_valid_o; endproperty
  property p_err_sum; (s_rd_os or s_rd_is) |-> io_rdata_o[4] == |io_rdata_o[8:5]; endproperty
  property p_out_rdy; s_rd_os |-> irq_o.out_rdy == (io_rdata_o[0] & io_rdata_o[3]); endproperty
  property p_in_rdy; s_rd_is |-> irq_o.in_rdy == (io_rdata_o[0] & io_rdata_o[3]); endproperty
  property p_in_err; s_rd_is |-> irq_o.in_err == (io_rdata_o[1] & io_rdata_o[4]); endproperty
  property p_out_err; s_rd_os |-> irq_o.out_err == (io_rdata_o[1] & io_rdata_o[4]); endproperty

  a_ack: assert property (p_ack) else $error("mapped access not answered");
  a_noack: assert property (p_noack) else $error("answer without mapped access");
  a_tx_hold: assert property (p_tx_hold) else $error("offered character dropped");
  a_tx_done: assert property (p_tx_done) else $error("offer held after accept");
  a_mclr: assert property (p_mclr) else $error("master clear incomplete");
  a_err_sum: assert property (p_err_sum) else $error("error summary wrong");
  a_out_rdy: assert property (p_out_rdy) else $error("output ready request wrong");
  a_in_rdy: assert property (p_in_rdy) else $error("input ready request wrong");
  a_in_err: assert property (p_in_err) else $error("input error request wrong");
  a_out_err: assert property (p_out_err) else $error("output error request wrong");
endmodule

bind ioc_channel ioc_assertions #(.DEV_NO(DEV_NO), .CHAR_W(CHAR_W)) u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .mclr_i(mclr_i), .io_req_i(io_req_i), .io_rdata_o(io_rdata_o), .io_ack_o(io_ack_o), .rx_valid_i(rx_valid_i),
  .rx_data_i(rx_data_i), .rx_err_i(rx_err_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
  .tx_ready_i(tx_ready_i), .tx_err_i(tx_err_i), .irq_o(irq_o));

// *** tb/ioc_dev_model.sv ***
`timescale 1ns/10ps

module ioc_dev_model #(
  parameter int CHAR_W = 8,  // Character width
  parameter int DELAY  = 6   // Cycles before a character is taken
) (
  // Clock
  input  wire logic              clk_i,
  // Transmit side
  input  wire logic              tx_valid_i,
  input  wire logic [CHAR_W-1:0] tx_data_i,
  output logic                   tx_ready_o,
  output logic                   tx_err_o,
  // Receive side
  output logic                   rx_valid_o,
  output logic      [CHAR_W-1:0] rx_data_o,
  output logic                   rx_err_o
);
  int              wait_n = 0;  // Stall counter
  int              count  = 0;  // Characters taken
  logic [CHAR_W-1:0] got;       // Last character taken
  logic [CHAR_W:0]   pend[$];   // Characters to deliver

  initial begin
    tx_ready_o = 1'b0;
    tx_err_o   = 1'b0;
    rx_valid_o = 1'b0;
    rx_data_o  = '0;
    rx_err_o   = 1'b0;
  end

  // Queue one character, return at the clock edge after it goes on the wire
  task automatic put(input logic [CHAR_W-1:0] c, input logic e);
    pend.push_back({e, c});
    wait (pend.size() == 0);
    @(posedge clk_i);
  endtask

  // Slow acceptor and receive driver; idle lines carry changing junk
  always @(posedge clk_i) begin
    #1;
    tx_err_o = tx_valid_i ? 1'b0 : ~tx_err_o;
    if (tx_valid_i && !tx_ready_o) begin
      wait_n = wait_n + 1;
    end
    if (wait_n == DELAY) begin
      tx_ready_o = 1'b1;
      got = tx_data_i;
      count++;
      wait_n = 0;
    end else begin
      tx_ready_o = 1'b0;
    end
    if (pend.size() != 0) begin
      {rx_err_o, rx_data_o} = pend.pop_front();
      rx_valid_o = 1'b1;
    end else begin
      rx_valid_o = 1'b0;
      rx_data_o  = ~rx_data_o;
      rx_err_o   = ~rx_err_o;
    end
  end
endmodule

// *** tb/tb.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end

module tb;
  localparam logic [15:0] DEV = 16'h00C0;  // Device number
  localparam logic [15:0] DEV_DMA = 16'h00D0;  // Device number of the DMA build

  logic                 clk_i = 1'b0;
  logic                 rst_n_i;
  logic                 mclr_i;
  ioc_pkg::ioc_io_req_t req;
  logic          [15:0] io_rdata_o;
  logic                 io_ack_o;
  logic          [15:0] rdata_dma;  // Read answer of the DMA build
  logic                 ack_dma;    // Access answer of the DMA build
  logic                 rx_valid, rx_err, tx_valid, tx_ready, tx_err;
  logic           [7:0] rx_data, tx_data, ch;
  ioc_pkg::ioc_irq_t    irq_o;
  logic          [16:0] exp_q[$];  // Compare flag and expected answer
  logic          [16:0] e;
  logic          [15:0] rnd = 16'h0037;
  logic          [15:0] c;
  int                   fails = 0;
  int                   checks_done = 0;

  always #10 clk_i = ~clk_i;

  ioc_channel dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .mclr_i(mclr_i), .io_req_i(req), .io_rdata_o(io_rdata_o),
    .io_ack_o(io_ack_o), .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_err_i(rx_err), .tx_valid_o(tx_valid),
    .tx_data_o(tx_data), .tx_ready_i(tx_ready), .tx_err_i(tx_err), .irq_o(irq_o));

  // DMA build: data registers hidden, shares the request bus
  ioc_channel #(.DEV_NO(DEV_DMA), .CHAR_W(8), .DMA_STYLE(1'b1)) dut_dma (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .mclr_i(mclr_i), .io_req_i(req), .io_rdata_o(rdata_dma), .io_ack_o(ack_dma), .rx_valid_i(rx_valid),
    .rx_data_i(rx_data), .rx_err_i(rx_err), .tx_valid_o(), .tx_data_o(), .tx_ready_i(tx_ready),
    .tx_err_i(tx_err), .irq_o());

  ioc_dev_model dev (.clk_i(clk_i), .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready),
    .tx_err_o(tx_err), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_err_o(rx_err));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // One processor access; mapped ones note their answer
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d, input logic [15:0] x);
    @(posedge clk_i);
    #1;
    req = '{rd: !w, wr: w, addr: a, wdata: d};
    if (a - DEV < 16'h0008 || a - DEV_DMA < 16'h0008) exp_q.push_back({!w, x});
    @(posedge clk_i);
    #1;
    req.rd = 1'b0;
    req.wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] r, input logic [15:0] x);
    acc(1'b0, DEV + r, 16'h0000, x);
  endtask

  task automatic wr(input logic [15:0] r, input logic [15:0] d);
    acc(1'b1, DEV + r, d, 16'h0000);
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Answer watcher takes the oldest note
  always @(negedge clk_i) begin
    if (io_ack_o !== 1'b0 || ack_dma !== 1'b0) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("wrong value at %0t: unexpected answer", $time);
      end else begin
        e = exp_q.pop_front();
        if (e[16]) `CHK(ack_dma === 1'b1 ? rdata_dma : io_rdata_o, e[15:0])
      end
    end
  end

  // Watchdog
  initial begin
    #200000;
    fails++;
    conclude();
  end

  // Main sequence
  initial begin
    req = '0;
    mclr_i = 1'b0;
    rst_n_i = 1'b0;
    repeat (8) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    rd(6, 16'h0008);
    rd(2, 16'h0000);
    rd(1, 16'h0000);
    acc(1'b0, DEV + 16'h0008, 16'h0000, 16'h0000);
    acc(1'b1, DEV - 16'h0001, 16'h0010, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      c = rnd & 16'hFE07;
      wr(7, c);
      rd(6, c | 16'h0008);
      wr(3, c);
      rd(2, c);
    end
    wr(7, 16'h0001);
    repeat (3) @(posedge clk_i);
    #1;
    `CHK(irq_o.out_rdy, 1'b1)
    wr(3, 16'h0010);
    rd(6, 16'h0008);
    rd(2, 16'h0000);
    `CHK(irq_o.out_rdy, 1'b0)
    wr(3, 16'h0006);
    dev.put(8'h5A, 1'b0);
    rd(2, 16'h000E);
    rd(0, 16'h005A);
    rd(2, 16'h0006);
    rnd = lfsr(rnd);
    dev.put(rnd[15:8], 1'b0);
    dev.put(rnd[7:0], 1'b1);
    rd(2, 16'h007E);
    `CHK(irq_o.in_err, 1'b1)
    rd(0, {8'h00, rnd[7:0]});
    wr(3, 16'h0010);
    rnd = lfsr(rnd);
    ch = rnd[7:0];
    wr(7, 16'h0006);
    wr(5, {8'h00, ch});
    rd(6, 16'h0006);
    wr(5, 16'h00FF);
    rd(6, 16'h0036);
    `CHK(irq_o.out_err, 1'b1)
    repeat (12) @(posedge clk_i);
    `CHK(dev.got, ch)
    `CHK(dev.count, 1)
    rd(6, 16'h003E);
    @(posedge clk_i);
    #1 mclr_i = 1'b1;
    @(posedge clk_i);
    #1 mclr_i = 1'b0;
    rd(6, 16'h0008);
    rd(2, 16'h0000);
    wr(3, 16'h0004);
    wr(7, 16'h000C);
    wr(5, {8'h00, ~ch});
    repeat (2) @(posedge clk_i);
    rd(2, 16'h000C);
    rd(0, {8'h00, ~ch});
    rd(6, 16'h000C);
    `CHK(dev.count, 1)
    acc(1'b1, DEV_DMA + 16'h0007, 16'h0004, 16'h0000);
    acc(1'b1, DEV_DMA + 16'h0005, 16'h0041, 16'h0000);
    acc(1'b0, DEV_DMA + 16'h0006, 16'h0000, 16'h000C);
    acc(1'b0, DEV_DMA + 16'h0000, 16'h0000, 16'h0000);
    repeat (3) @(posedge clk_i);
    `CHK(exp_q.size(), 0)
    conclude();
  end
endmodule
